// File: src/sercon_pkg.sv
package sercon_pkg;
	// ------------------------------------------------------------
	// Register offsets (8-bit host view)
	// ------------------------------------------------------------
	localparam logic [6:0] channel_command = 7'h01;
	localparam logic [6:0] service_request_enable = 7'h02;
	localparam logic [6:0] channel_option_one = 7'h03;
	localparam logic [6:0] channel_option_two = 7'h04;
	localparam logic [6:0] channel_option_three = 7'h05;
	localparam logic [6:0] channel_control_status = 7'h06;
	localparam logic [6:0] rx_byte_count = 7'h07;
	localparam logic [6:0] special_char_one = 7'h09;
	localparam logic [6:0] special_char_four = 7'h0C;
	localparam logic [6:0] modem_change_option_one = 7'h10;
	localparam logic [6:0] modem_change_option_two = 7'h11;
	localparam logic [6:0] modem_change_flags = 7'h12;
	localparam logic [6:0] rx_timeout_period = 7'h18;
	localparam logic [6:0] modem_signal_value = 7'h28;
	localparam logic [6:0] modem_rts_only_value = 7'h29;
	localparam logic [6:0] modem_dtr_only_value = 7'h2A;
	localparam logic [6:0] rx_rate_divisor_high = 7'h31;
	localparam logic [6:0] rx_rate_divisor_low = 7'h32;
	localparam logic [6:0] rx_bit_state = 7'h33;
	localparam logic [6:0] tx_rate_divisor_high = 7'h39;
	localparam logic [6:0] tx_rate_divisor_low = 7'h3A;
	localparam logic [6:0] interrupt_vector = 7'h40;
	localparam logic [6:0] current_channel_one = 7'h41;
	localparam logic [6:0] current_channel_three = 7'h43;
	localparam logic [6:0] modem_service_match = 7'h61;
	localparam logic [6:0] rx_service_match = 7'h63;
	localparam logic [6:0] channel_select = 7'h64;
	localparam logic [6:0] request_status = 7'h65;
	localparam logic [6:0] request_config = 7'h66;
	localparam logic [6:0] firmware_revision = 7'h6B;
	localparam logic [6:0] prescaler_period_high = 7'h70;
	localparam logic [6:0] prescaler_period_low = 7'h71;
	localparam logic [6:0] modem_request_ack = 7'h75;
	localparam logic [6:0] tx_request_ack = 7'h76;
	localparam logic [6:0] rx_request_ack = 7'h77;
	localparam logic [6:0] rx_data = 7'h78;
	localparam logic [6:0] rx_char_status = 7'h7A;
	localparam logic [6:0] tx_data = 7'h7B;
	localparam logic [6:0] end_of_service = 7'h7F;
	// ------------------------------------------------------------
	// Reset values and fields
	// ------------------------------------------------------------
	localparam logic [7:0] rst_zero = 8'h00;
	localparam logic [7:0] rst_ff = 8'hFF;
	localparam logic [7:0] rst_ack = 8'h80;
	localparam logic [7:0] rst_timeout = 8'h05;
	localparam logic [7:0] rst_rx_bit_state = 8'h21;
	// Arbitrary value, not a real revision code
	localparam logic [7:0] rst_revision = 8'h5A;
	localparam logic [7:0] config_wmask = 8'h7B;
	localparam int package_type_bit = 7;
	localparam int register_ack_enable = 6;
	localparam int chain_ack_enable = 5;
	localparam int priority_select = 0;
	localparam logic [7:0] rx_count_mask = 8'h0F;
	localparam logic [7:0] chan_field_mask = 8'h1C;
	localparam logic [7:0] rts_mask = 8'h01;
	localparam logic [7:0] dtr_mask = 8'h02;
	localparam logic [7:0] modem_out_mask = 8'h03;
	localparam int num_chan = 8;
	// ------------------------------------------------------------
	// APB controller registers (word offsets)
	// ------------------------------------------------------------
	localparam logic [3:0] ctl_addr_off = 4'h0;
	localparam logic [3:0] ctl_wdata_off = 4'h4;
	localparam logic [3:0] ctl_cmd_off = 4'h8;
	localparam logic [3:0] ctl_stat_off = 4'hC;
	localparam logic [3:0] ctl_rdata_off = 4'h0;
	localparam logic [3:0] ctl_mask_off = 4'h4;
	localparam logic [31:0] apb_bad_data = 32'h0000_0000;
endpackage

// File: src/sercon_if.sv
interface sercon_if;
	logic [6:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic cs;
	logic wr;
	modport dev (input addr, input wdata, input cs, input wr, output rdata);
	modport host (output addr, output wdata, output cs, output wr, input rdata);
endinterface

// File: src/sercon_chan_bank.sv
// Per-channel register bank, one entry per channel in arrays
module sercon_chan_bank #(
	parameter int CHANNELS = 8
) (
	input wire logic i_clk_sys,
	input wire logic i_resetn,
	input wire logic [2:0] i_chan,
	input wire logic i_we,
	input wire logic [6:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic [2:0] i_modem_in,
	output logic [7:0] o_rdata,
	output logic [CHANNELS*2-1:0] o_modem_out
);
	// Offsets 0x00 to 0x12 each get their own entry, so 0x1x never aliases 0x0x
	logic [7:0] opt_r [CHANNELS][19];
	logic [7:0] tmo_r [CHANNELS];
	logic [7:0] msv_r [CHANNELS];
	logic [7:0] rate_r [CHANNELS][4];

	// ------------------------------------------------------------
	// Storage; writes accepted at every offset up to 0x12 and at mapped bank offsets
	// ------------------------------------------------------------
	for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
		always_ff @(posedge i_clk_sys) begin
			if (!i_resetn) begin
				for (int k = 0; k < 19; k++) begin
					opt_r[c][k] <= sercon_pkg::rst_zero;
				end
				for (int k = 0; k < 4; k++) begin
					rate_r[c][k] <= sercon_pkg::rst_zero;
				end
				tmo_r[c] <= sercon_pkg::rst_timeout;
				msv_r[c] <= sercon_pkg::rst_zero;
			end else if (i_we && i_chan == 3'(c)) begin
				unique case (i_addr)
					sercon_pkg::rx_timeout_period: tmo_r[c] <= i_wdata;
					sercon_pkg::modem_signal_value: msv_r[c] <= i_wdata & sercon_pkg::modem_out_mask;
					sercon_pkg::modem_rts_only_value: begin
						msv_r[c] <= (msv_r[c] & ~sercon_pkg::rts_mask) | (i_wdata & sercon_pkg::rts_mask);
					end
					sercon_pkg::modem_dtr_only_value: begin
						msv_r[c] <= (msv_r[c] & ~sercon_pkg::dtr_mask) | (i_wdata & sercon_pkg::dtr_mask);
					end
					sercon_pkg::rx_rate_divisor_high: rate_r[c][0] <= i_wdata;
					sercon_pkg::rx_rate_divisor_low: rate_r[c][1] <= i_wdata;
					sercon_pkg::tx_rate_divisor_high: rate_r[c][2] <= i_wdata;
					sercon_pkg::tx_rate_divisor_low: rate_r[c][3] <= i_wdata;
					default: begin
						if (i_addr <= 7'h12) begin
							opt_r[c][i_addr[4:0]] <= i_wdata;
						end
					end
				endcase
			end
		end
		assign o_modem_out[c*2 +: 2] = msv_r[c][1:0];
	end

	// ------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------
	always_comb begin
		o_rdata = sercon_pkg::rst_zero;
		unique case (i_addr)
			sercon_pkg::rx_timeout_period: o_rdata = tmo_r[i_chan];
			sercon_pkg::modem_signal_value: o_rdata = {i_modem_in, 3'b000, msv_r[i_chan][1:0]};
			sercon_pkg::rx_rate_divisor_high: o_rdata = rate_r[i_chan][0];
			sercon_pkg::rx_rate_divisor_low: o_rdata = rate_r[i_chan][1];
			sercon_pkg::tx_rate_divisor_high: o_rdata = rate_r[i_chan][2];
			sercon_pkg::tx_rate_divisor_low: o_rdata = rate_r[i_chan][3];
			sercon_pkg::rx_bit_state: o_rdata = sercon_pkg::rst_rx_bit_state;
			sercon_pkg::rx_byte_count: o_rdata = sercon_pkg::rst_zero;
			default: begin
				if (i_addr <= 7'h12 && i_addr != sercon_pkg::channel_control_status) begin
					o_rdata = opt_r[i_chan][i_addr[4:0]];
				end
			end
		endcase
	end
endmodule

// File: src/sercon_device.sv
// Behaviour
// - Writes land at 0x00-0x12, mapped bank registers and 0x40 up, read-only included
// - 16-bit host wires device A0 to A1
// - Unsteered 32-bit host shifts addresses two
// - Big-endian 16-bit host uses odd addresses
// - Little-endian 16-bit host uses even addresses
// - Request config resets zero, fixed bit layout
// - Request status read-only: level, request flags
// - Acknowledge registers reset 0x80, return vector
// - Channel registers hold channel in bits 4:2
// - Receive count in bits 3:0, upper zero
// - Receive status: timeout, detect code, errors
// - Rate divisors are byte pairs, reset zero
// - Prescaler period bytes reset to 0xFF
// - Receive timeout period resets to five
// - Modem option: zero-detect enables, ready threshold
// - Modem value register plus single-signal aliases
// - Option three holds receive FIFO threshold
// - Host writes end-of-service after each routine
module sercon_device (
	input wire logic i_clk_sys,
	input wire logic i_resetn,
	sercon_if.dev bus,
	input wire logic [2:0] i_modem_in,
	input wire logic i_rx_req,
	input wire logic i_tx_req,
	input wire logic i_modem_req,
	input wire logic [2:0] i_req_chan,
	output logic [15:0] o_modem_out,
	output logic [15:0] o_prescaler,
	output logic o_eos
);
	logic [7:0] glob_r [128];
	logic [1:0] ack_level_r;
	logic [2:0] ack_type;
	logic [7:0] vec_mod;
	logic [7:0] bank_rdata;
	logic [7:0] rdata_nxt;
	logic we;
	logic rd;
	logic is_ack;
	logic have_req;

	assign we = bus.cs && bus.wr;
	assign rd = bus.cs && !bus.wr;
	assign is_ack = bus.addr >= sercon_pkg::modem_request_ack && bus.addr <= sercon_pkg::rx_request_ack;

	// ------------------------------------------------------------
	// Per-channel bank
	// ------------------------------------------------------------
	sercon_chan_bank #(.CHANNELS(sercon_pkg::num_chan)) u_bank (
		.i_clk_sys(i_clk_sys),
		.i_resetn(i_resetn),
		.i_chan(glob_r[sercon_pkg::channel_select][2:0]),
		.i_we(we),
		.i_addr(bus.addr),
		.i_wdata(bus.wdata),
		.i_modem_in(i_modem_in),
		.o_rdata(bank_rdata),
		.o_modem_out(o_modem_out)
	);

	// ------------------------------------------------------------
	// Acknowledge: vector low bits carry the service type
	// ------------------------------------------------------------
	always_comb begin
		unique case (bus.addr[1:0])
			2'b01: have_req = i_modem_req;
			2'b10: have_req = i_tx_req;
			default: have_req = i_rx_req;
		endcase
		ack_type = have_req ? {1'b0, bus.addr[1:0]} : 3'b000;
		vec_mod = {glob_r[sercon_pkg::interrupt_vector][7:3], ack_type};
	end

	// ------------------------------------------------------------
	// Global storage
	// ------------------------------------------------------------
	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			for (int k = 0; k < 128; k++) begin
				glob_r[k] <= sercon_pkg::rst_zero;
			end
			glob_r[sercon_pkg::interrupt_vector] <= sercon_pkg::rst_ff;
			glob_r[sercon_pkg::prescaler_period_high] <= sercon_pkg::rst_ff;
			glob_r[sercon_pkg::prescaler_period_low] <= sercon_pkg::rst_ff;
			glob_r[sercon_pkg::firmware_revision] <= sercon_pkg::rst_revision;
		end else if (we && bus.addr >= sercon_pkg::interrupt_vector) begin
			if (bus.addr == sercon_pkg::request_config) begin
				glob_r[bus.addr] <= bus.wdata & sercon_pkg::config_wmask;
			end else begin
				glob_r[bus.addr] <= bus.wdata;
			end
		end else if (rd && is_ack && glob_r[sercon_pkg::request_config][sercon_pkg::register_ack_enable]) begin
			// Acknowledge loads channel into the three channel registers
			for (int k = 0; k < 3; k++) begin
				glob_r[sercon_pkg::current_channel_one + 7'(k)] <= {3'b000, i_req_chan, 2'b00};
			end
		end
	end

	// Acknowledge level held until end of service
	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			ack_level_r <= 2'b00;
		end else if (we && bus.addr == sercon_pkg::end_of_service) begin
			ack_level_r <= 2'b00;
		end else if (rd && is_ack && glob_r[sercon_pkg::request_config][sercon_pkg::register_ack_enable]) begin
			ack_level_r <= ack_type[1:0];
		end
	end

	// ------------------------------------------------------------
	// Read path, registered data
	// ------------------------------------------------------------
	always_comb begin
		rdata_nxt = bank_rdata;
		if (bus.addr >= sercon_pkg::interrupt_vector) begin
			rdata_nxt = glob_r[bus.addr];
		end
		if (bus.addr == sercon_pkg::request_status) begin
			rdata_nxt = {ack_level_r, i_rx_req, i_rx_req, i_tx_req, i_tx_req, i_modem_req, i_modem_req};
		end else if (is_ack) begin
			rdata_nxt = glob_r[sercon_pkg::request_config][sercon_pkg::register_ack_enable] ? vec_mod
				: sercon_pkg::rst_ack;
		end else if (bus.addr == sercon_pkg::rx_char_status || bus.addr == sercon_pkg::rx_data) begin
			rdata_nxt = sercon_pkg::rst_zero;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			bus.rdata <= sercon_pkg::rst_zero;
		end else if (rd) begin
			bus.rdata <= rdata_nxt;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			o_eos <= 1'b0;
		end else begin
			o_eos <= we && bus.addr == sercon_pkg::end_of_service;
		end
	end

	assign o_prescaler = {glob_r[sercon_pkg::prescaler_period_high], glob_r[sercon_pkg::prescaler_period_low]};
endmodule

// File: src/sercon_host.sv
// APB-driven host: issues one byte access per command
module sercon_host (
	input wire logic i_clk_sys,
	input wire logic i_resetn,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [3:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	output logic o_irq,
	sercon_if.host bus
);
	typedef enum logic [1:0] {st_idle, st_drive, st_sample} host_st_t;
	host_st_t st_r;
	logic [6:0] addr_r;
	logic [7:0] wdata_r;
	logic [7:0] rdata_r;
	logic [1:0] status_r;
	logic [1:0] mask_r;
	logic wr_r;
	logic access;
	logic wr_acc;
	logic rd_acc;

	assign access = i_psel && i_penable;
	assign wr_acc = access && i_pwrite;
	assign rd_acc = access && !i_pwrite;
	assign o_pready = 1'b1;
	assign o_pslverr = 1'b0;
	assign o_irq = |(status_r & mask_r);

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			addr_r <= 7'h00;
			wdata_r <= 8'h00;
			wr_r <= 1'b0;
			mask_r <= 2'b00;
		end else if (wr_acc) begin
			unique case (i_paddr)
				sercon_pkg::ctl_addr_off: addr_r <= i_pwdata[6:0];
				sercon_pkg::ctl_wdata_off: wdata_r <= i_pwdata[7:0];
				sercon_pkg::ctl_cmd_off: wr_r <= i_pwdata[0];
				sercon_pkg::ctl_stat_off: mask_r <= i_pwdata[1:0];
				default: ;
			endcase
		end
	end

	// One setup cycle, then sample read data
	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			st_r <= st_idle;
			rdata_r <= 8'h00;
		end else begin
			unique case (st_r)
				st_idle: if (wr_acc && i_paddr == sercon_pkg::ctl_cmd_off && st_r == st_idle) st_r <= st_drive;
				st_drive: st_r <= st_sample;
				st_sample: begin
					rdata_r <= bus.rdata;
					st_r <= st_idle;
				end
			endcase
		end
	end

	// Status bit0: done, bit1: end-of-service written; read clears, set wins
	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			status_r <= 2'b00;
		end else begin
			status_r <= (rd_acc && i_paddr == sercon_pkg::ctl_stat_off) ? 2'b00 : status_r;
			if (st_r == st_sample) begin
				status_r[0] <= 1'b1;
				status_r[1] <= wr_r && addr_r == sercon_pkg::end_of_service;
			end
		end
	end

	always_comb begin
		o_prdata = sercon_pkg::apb_bad_data;
		unique case (i_paddr)
			sercon_pkg::ctl_addr_off: o_prdata = {24'h0, rdata_r};
			sercon_pkg::ctl_mask_off: o_prdata = {30'h0, mask_r};
			sercon_pkg::ctl_cmd_off: o_prdata = {31'h0, st_r != st_idle};
			sercon_pkg::ctl_stat_off: o_prdata = {30'h0, status_r};
			default: ;
		endcase
	end

	// 8-bit host: device address used directly (no lane shift)
	assign bus.addr = addr_r;
	assign bus.wdata = wdata_r;
	assign bus.cs = st_r == st_drive;
	assign bus.wr = wr_r;
endmodule

// File: testbench/sercon_map_asserts.sv
module sercon_map_asserts (
	input wire logic i_clk_sys,
	input wire logic i_resetn,
	input wire logic [6:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata,
	input wire logic cs,
	input wire logic wr
);
	// --------------------------------
	// Mirrors of global registers
	// --------------------------------
	logic [7:0] cfg_r;
	logic [7:0] vec_r;
	logic [7:0] pph_r;
	logic [7:0] ppl_r;
	logic rd;
	logic [1:0] ack_sel;
	assign rd = cs && !wr;
	assign ack_sel = addr[1:0];
	// Only global offsets, so the selected channel never matters here
	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			cfg_r <= 8'h00;
			vec_r <= 8'hFF;
			pph_r <= 8'hFF;
			ppl_r <= 8'hFF;
		end else if (cs && wr) begin
			case (addr)
				7'h66: cfg_r <= wdata;
				7'h40: vec_r <= wdata;
				7'h70: pph_r <= wdata;
				7'h71: ppl_r <= wdata;
				default: ;
			endcase
		end
	end
	// --------------------------------
	// Properties
	// --------------------------------
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_resetn);
	property p_cs_pulse; cs |=> !cs; endproperty
	a_cs_pulse: assert property (p_cs_pulse) else $error("strobe held past one cycle");
	property p_rdata_cause; $changed(rdata) |-> $past(cs); endproperty
	a_rdata_cause: assert property (p_rdata_cause) else $error("read data moved without access");
	property p_config_fixed; rd && addr == 7'h66 |=> rdata == (cfg_r & 8'h7B); endproperty
	a_config_fixed: assert property (p_config_fixed) else $error("config readback wrong");
	property p_count_upper; rd && addr == 7'h07 |=> rdata[7:4] == 4'h0; endproperty
	a_count_upper: assert property (p_count_upper) else $error("count upper bits set");
	property p_ack_off; rd && addr inside {7'h75, 7'h76, 7'h77} && !cfg_r[6] |=> rdata == 8'h80; endproperty
	a_ack_off: assert property (p_ack_off) else $error("disabled acknowledge value wrong");
	property p_ack_vector;
		rd && addr inside {7'h75, 7'h76, 7'h77} && cfg_r[6] |=>
			rdata[7:3] == vec_r[7:3] && (rdata[2:0] == 3'h0 || rdata[2:0] == {1'b0, $past(ack_sel)});
	endproperty
	a_ack_vector: assert property (p_ack_vector) else $error("acknowledge vector wrong");
	property p_presc_high; rd && addr == 7'h70 |=> rdata == pph_r; endproperty
	a_presc_high: assert property (p_presc_high) else $error("prescaler high wrong");
	property p_presc_low; rd && addr == 7'h71 |=> rdata == ppl_r; endproperty
	a_presc_low: assert property (p_presc_low) else $error("prescaler low wrong");
	c_ack_read: cover property (rd && addr == 7'h77 && cfg_r[6]);
	c_config_write: cover property (cs && wr && addr == 7'h66);
	c_presc_read: cover property (rd && addr == 7'h70);
endmodule

// File: testbench/multichannel_serial_register_map_tb.sv
module multichannel_serial_register_map_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clk_sys = 1'b0;
	logic i_resetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [3:0] paddr = 4'h0;
	logic [31:0] pwdata = 32'h0;
	logic [2:0] modem_in = 3'h0;
	logic [2:0] req_chan = 3'h0;
	logic [2:0] reqs = 3'h0;
	logic [31:0] prdata, stat, x;
	logic pready, pslverr, irq, eos;
	logic [15:0] modem_out, prescaler, mo;
	logic [7:0] r, v;
	logic [7:0] mdl [logic [6:0]];
	int n_mismatch = 0;
	int samples_checked = 0;
	int n_eos = 0;
	int ch;
	logic [6:0] ra [18] = '{7'h66, 7'h65, 7'h75, 7'h76, 7'h77, 7'h41, 7'h07, 7'h7A, 7'h31, 7'h32, 7'h39,
		7'h3A, 7'h70, 7'h71, 7'h18, 7'h40, 7'h33, 7'h6B};
	logic [7:0] rv [18] = '{8'h00, 8'h00, 8'h80, 8'h80, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'hFF, 8'hFF, 8'h05, 8'hFF, 8'h21, sercon_pkg::rst_revision};
	logic [6:0] wa [11] = '{7'h18, 7'h31, 7'h32, 7'h39, 7'h3A, 7'h70, 7'h71, 7'h05, 7'h40, 7'h6B, 7'h41};
	logic [6:0] ma [4] = '{7'h28, 7'h29, 7'h2A, 7'h29};
	logic [7:0] md [4] = '{8'h03, 8'h00, 8'h00, 8'h01};
	logic [1:0] me [4] = '{2'b11, 2'b10, 2'b00, 2'b01};
	sercon_if bus ();
	sercon_host i_sercon_host (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
		.o_pslverr(pslverr), .o_irq(irq), .bus(bus.host));
	sercon_device i_sercon_device (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .bus(bus.dev), .i_modem_in(modem_in),
		.i_rx_req(reqs[2]), .i_tx_req(reqs[1]), .i_modem_req(reqs[0]), .i_req_chan(req_chan),
		.o_modem_out(modem_out), .o_prescaler(prescaler), .o_eos(eos));
	sercon_map_asserts i_checker (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .addr(bus.addr), .wdata(bus.wdata),
		.rdata(bus.rdata), .cs(bus.cs), .wr(bus.wr));
	initial begin
		forever #10 i_clk_sys = ~i_clk_sys;
	end
	always @(posedge i_clk_sys) begin
		if (eos === 1'b1) n_eos++;
	end
	// --------------------------------
	// Bus tasks
	// --------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic [3:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge i_clk_sys);
		penable <= 1'b1;
		@(posedge i_clk_sys);
		while (pready !== 1'b1) @(posedge i_clk_sys);
		q = prdata;
		chk({31'h0, pslverr}, 32'h0);
		psel <= 1'b0;
		penable <= 1'b0;
		// Idle edge keeps back-to-back calls from driving psel twice at once
		@(posedge i_clk_sys);
	endtask
	task automatic dev(input logic [6:0] a, input logic w, input logic [7:0] d, output logic [7:0] q);
		apb(4'h0, 1'b1, {25'h0, a}, x);
		apb(4'h4, 1'b1, {24'h0, d}, x);
		apb(4'h8, 1'b1, {31'h0, w}, x);
		stat = 32'h0;
		while (stat[0] !== 1'b1) apb(4'hC, 1'b0, 32'h0, stat);
		apb(4'h0, 1'b0, 32'h0, x);
		q = x[7:0];
	endtask
	task automatic put(input logic [6:0] a, input logic [7:0] d);
		dev(a, 1'b1, d, r);
	endtask
	task automatic look(input logic [6:0] a, input logic [7:0] e);
		dev(a, 1'b0, 8'h00, r);
		chk({24'h0, r}, {24'h0, e});
	endtask
	task automatic end_sim;
		$display("checked %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// --------------------------------
	// Tests
	// --------------------------------
	initial begin
		void'($urandom(4));
		repeat (16) @(posedge i_clk_sys);
		i_resetn <= 1'b1;
		@(posedge i_clk_sys);
		foreach (ra[i]) mdl[ra[i]] = rv[i];
		chk({16'h0, prescaler}, 32'h0000_FFFF);
		foreach (ra[i]) look(ra[i], mdl[ra[i]]);
		apb(4'h2, 1'b0, 32'h0, x);
		chk(x, sercon_pkg::apb_bad_data);
		for (int k = 1; k < 8; k++) begin
			if (k != 5) put(ra[k], 8'hA5);
			if (k != 5) look(ra[k], mdl[ra[k]]);
		end
		foreach (wa[i]) begin
			v = 8'($urandom);
			put(wa[i], v);
			mdl[wa[i]] = v;
		end
		foreach (wa[i]) look(wa[i], mdl[wa[i]]);
		chk({16'h0, prescaler}, {16'h0, mdl[7'h70], mdl[7'h71]});
		ch = 1 + ($urandom % 7);
		put(7'h64, 8'(ch));
		look(7'h18, 8'h05);
		look(7'h32, 8'h00);
		put(7'h66, 8'hFF);
		look(7'h66, 8'h7B);
		put(7'h66, 8'h40);
		v = mdl[7'h40];
		look(7'h75, {v[7:3], 3'h0});
		put(7'h7F, 8'h00);
		for (int k = 0; k < 3; k++) begin
			reqs <= 3'b001 << k;
			req_chan <= 3'($urandom);
			@(posedge i_clk_sys);
			look(7'(7'h75 + k), {v[7:3], 3'(k + 1)});
			look(7'h41, {3'h0, req_chan, 2'h0});
			ch = n_eos;
			put(7'h7F, 8'($urandom));
			chk({31'h0, stat[1]}, 32'h1);
			chk(32'(n_eos - ch), 32'h1);
		end
		reqs <= 3'h0;
		ch = $urandom % 8;
		modem_in <= 3'($urandom);
		put(7'h64, 8'(ch));
		mo = 16'h0;
		foreach (ma[i]) begin
			put(ma[i], md[i]);
			mo[2*ch +: 2] = me[i];
			chk({16'h0, modem_out}, {16'h0, mo});
			look(7'h28, {modem_in, 3'h0, me[i]});
		end
		for (int m = 1; m >= 0; m--) begin
			apb(4'hC, 1'b1, 32'(m), x);
			apb(4'h4, 1'b0, 32'h0, x);
			chk(x, 32'(m));
			apb(4'h0, 1'b1, 32'h40, x);
			apb(4'h8, 1'b1, 32'h0, x);
			repeat (4) @(posedge i_clk_sys);
			chk({31'h0, irq}, 32'(m));
			apb(4'hC, 1'b0, 32'h0, stat);
			chk({31'h0, stat[0]}, 32'h1);
			chk({31'h0, irq}, 32'h0);
		end
		i_resetn <= 1'b0;
		repeat (2) @(posedge i_clk_sys);
		i_resetn <= 1'b1;
		@(posedge i_clk_sys);
		look(7'h70, 8'hFF);
		look(7'h66, 8'h00);
		end_sim();
	end
	// Tests need about 1300 cycles; this leaves ample margin
	initial begin
		repeat (20000) @(posedge i_clk_sys);
		n_mismatch++;
		end_sim();
	end
endmodule
